// [sbsp_map.svh]
`ifndef SBSP_MAP_SVH
`define SBSP_MAP_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SBSP_ADDR_W 16
`define SBSP_BYTE_W 9
`define SBSP_DATA_W 8
`define SBSP_LOW_LSB 0
`define SBSP_HIGH_LSB 9
`define SBSP_LOW_PAR 8
`define SBSP_HIGH_PAR 17

// ----------------------------------------
// Buffering and timing
// ----------------------------------------
`define SBSP_WBUF_DEPTH 8
`define SBSP_RD_LAT 3

`endif

// [sbsp_pkg.sv]
`include "sbsp_map.svh"

package sbsp_pkg;

    typedef logic [17:0] sbsp_word_t;

    // Burst state: idle (deselected) or inside an access sequence
    typedef enum logic [1:0] {
        SBSP_IDLE = 2'h1,
        SBSP_BURST = 2'h2
    } sbsp_mode_e;

    // Byte-lane merge: mask bit 0 takes the low byte, bit 1 the high byte
    function automatic sbsp_word_t sbsp_merge(sbsp_word_t old_w, sbsp_word_t new_w, logic [1:0] mask);
        sbsp_word_t r;
        r = old_w;
        if (mask[0]) begin
            r[`SBSP_LOW_LSB +: `SBSP_BYTE_W] = new_w[`SBSP_LOW_LSB +: `SBSP_BYTE_W];
        end
        if (mask[1]) begin
            r[`SBSP_HIGH_LSB +: `SBSP_BYTE_W] = new_w[`SBSP_HIGH_LSB +: `SBSP_BYTE_W];
        end
        return r;
    endfunction : sbsp_merge

    // Low address bits of a burst: linear wraps modulo four, interleaved is XOR
    function automatic logic [1:0] sbsp_burst_lo(logic [1:0] first, logic [1:0] cnt, logic interleave);
        return interleave ? (first ^ cnt) : 2'(first + cnt);
    endfunction : sbsp_burst_lo

endpackage : sbsp_pkg

// [sbsp_wbuf.sv]
`timescale 1ns/1ps
`include "sbsp_map.svh"

// Posted-write buffer with address lookup so reads see pending writes
module sbsp_wbuf
    import sbsp_pkg::*;
#(
    parameter int ADDR_W = `SBSP_ADDR_W,
    parameter int DEPTH = `SBSP_WBUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ADDR_W-1:0] in_addr,
    input wire sbsp_word_t in_data,
    input wire logic [1:0] in_mask,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ADDR_W-1:0] out_addr,
    output sbsp_word_t out_data,
    output logic [1:0] out_mask,
    output logic is_full,
    input wire logic [ADDR_W-1:0] lk_addr,
    output sbsp_word_t lk_data,
    output logic [1:0] lk_mask
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        sbsp_word_t data;
        logic [1:0] mask;
    } sbsp_ent_s;

    typedef struct packed {
        sbsp_ent_s [DEPTH-1:0] ent;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sbsp_wbuf_s;

    sbsp_wbuf_s st_r;
    sbsp_wbuf_s st_nxt;
    logic push;
    logic pop;
    logic empty;

    // Extra pointer bit tells full from empty
    assign empty = (st_r.wp == st_r.rp);
    assign is_full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    assign out_valid = !empty;
    assign in_ready = !is_full || out_ready; // Slot freed by a pop is reusable at once
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_addr = st_r.ent[st_r.rp[AW-1:0]].addr;
    assign out_data = st_r.ent[st_r.rp[AW-1:0]].data;
    assign out_mask = st_r.ent[st_r.rp[AW-1:0]].mask;

    // Pointer and entry update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.ent[st_r.wp[AW-1:0]] = '{addr: in_addr, data: in_data, mask: in_mask};
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    // Oldest to newest, so younger writes override per byte
    always_comb begin
        logic [AW:0] idx;
        logic [AW:0] used;
        idx = '0;
        used = st_r.wp - st_r.rp;
        lk_data = '0;
        lk_mask = 2'h0;
        for (int i = 0; i < DEPTH; i++) begin
            idx = st_r.rp + (AW+1)'(i);
            if (((AW+1)'(i) < used) && (st_r.ent[idx[AW-1:0]].addr == lk_addr)) begin
                lk_data = sbsp_merge(lk_data, st_r.ent[idx[AW-1:0]].data, st_r.ent[idx[AW-1:0]].mask);
                lk_mask = lk_mask | st_r.ent[idx[AW-1:0]].mask;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

endmodule : sbsp_wbuf

// [sbsp_port.sv]
`timescale 1ns/1ps
`include "sbsp_map.svh"

// Operation
// - Array of 65536 words, 18 bits each
// - Two-bit counter makes follow-on burst addresses
// - All synchronous inputs captured on rising edge
// - Output enable and order select are asynchronous
// - Either address strobe captures address and selects
// - Later burst addresses internal, stepped by advance
// - Counter drives low two bits, upper held
// - Writes registered, then completed internally
// - Low enable low byte, high enable high byte
// - Byte enables act only with gate low
// - Global write low writes all 18 bits
// - Byte enable low means write, high read
// - Pins float when a byte write is signalled
// - Primary select enables and qualifies processor strobe
// - Second select active low, all selects needed
// - Burst read delivers words 3-1-1-1
// - Deselect releases data bus after one clock
// - Address, control, data and read data pipelined
// - Just-written data returned by later reads
// - Order select low linear, else interleaved
// - Advance high holds address, wait cycle
// - Processor strobe reads, controller strobe per controls

module sbsp_port
    import sbsp_pkg::*;
#(
    parameter int ADDR_W = `SBSP_ADDR_W,
    parameter int WBUF_DEPTH = `SBSP_WBUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic chip_select_n,
    input wire logic second_select_n,
    input wire logic third_select_high,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic byte_write_gate_n,
    input wire logic all_bytes_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order_sel,
    input wire logic [7:0] data_low_byte_in,
    input wire logic parity_low_byte_in,
    input wire logic [7:0] data_high_byte_in,
    input wire logic parity_high_byte_in,
    output logic [7:0] data_low_byte_out,
    output logic parity_low_byte_out,
    output logic [7:0] data_high_byte_out,
    output logic parity_high_byte_out,
    output logic data_low_byte_oe,
    output logic parity_low_byte_oe,
    output logic data_high_byte_oe,
    output logic parity_high_byte_oe
);

    localparam int WORDS = 1 << ADDR_W;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sbsp_mode_e mode;
        logic [ADDR_W-3:0] base;
        logic [1:0] start_lo;
        logic [1:0] cnt;
        logic rd1_v;
        logic [ADDR_W-1:0] rd1_addr;
        logic rd2_v;
        sbsp_word_t rd2_data;
        sbsp_word_t dout;
        logic doe;
    } sbsp_port_s;

    localparam sbsp_port_s PORT_RST = '{mode: SBSP_IDLE, default: '0};

    sbsp_port_s st_r;
    sbsp_port_s st_nxt;

    // Array storage, flip-flops indexed by word address
    sbsp_word_t mem [WORDS];

    logic sel_all;
    logic proc_go;
    logic ctrl_go;
    logic new_go;
    logic in_burst;
    logic cont;
    logic adv;
    logic desel_now;
    logic acc_now;
    logic is_write;
    logic float_now;
    logic [1:0] wr_mask;
    logic [1:0] cnt_next;
    logic [ADDR_W-1:0] acc_addr;
    sbsp_word_t din;
    sbsp_word_t mem_rd;
    sbsp_word_t lk_data;
    logic [1:0] lk_mask;
    logic push_rdy;
    logic wb_full;
    logic drain_v;
    logic drain_rdy;
    logic [ADDR_W-1:0] drain_addr;
    sbsp_word_t drain_data;
    logic [1:0] drain_mask;

    // ----------------------------------------
    // Input decode
    // ----------------------------------------

    // Data pins packed as one word, parity above each byte
    assign din = {parity_high_byte_in, data_high_byte_in, parity_low_byte_in, data_low_byte_in};

    // Per-byte write lanes; enables count only behind the gate
    assign wr_mask[0] = !all_bytes_write_n || (!byte_write_gate_n && !low_byte_write_n);
    assign wr_mask[1] = !all_bytes_write_n || (!byte_write_gate_n && !high_byte_write_n);

    // A signalled byte write floats the pins even before it is decoded
    assign float_now = !byte_write_gate_n && (!low_byte_write_n || !high_byte_write_n);

    // Selection needs every chip select at its active level
    assign sel_all = !chip_select_n && !second_select_n && third_select_high;

    // Processor strobe is ignored while the primary select is high
    assign proc_go = !proc_addr_strobe_n && !chip_select_n;

    // Processor strobe wins if both strobes come together with the primary select low
    assign ctrl_go = !ctrl_addr_strobe_n && !proc_go;
    assign new_go = proc_go || ctrl_go;

    // Burst continuation only while selected
    always_comb begin
        case (st_r.mode)
            SBSP_IDLE: in_burst = 1'b0;
            SBSP_BURST: in_burst = 1'b1;
            default: in_burst = 1'b0;
        endcase
    end

    assign cont = !new_go && in_burst;
    assign adv = cont && !burst_advance_n;

    // Advance low steps the counter, advance high repeats the address
    assign cnt_next = adv ? 2'(st_r.cnt + 2'h1) : st_r.cnt;

    // Upper bits stay as captured; counter supplies the low two
    assign acc_addr = new_go ? address_in
        : {st_r.base, sbsp_burst_lo(st_r.start_lo, cnt_next, burst_order_sel)};

    assign desel_now = new_go && !sel_all;
    assign acc_now = (new_go && sel_all) || cont;

    // A processor-strobe start is always a read
    assign is_write = acc_now && !proc_go && (|wr_mask);

    // ----------------------------------------
    // Posted writes
    // ----------------------------------------

    // The array port serves reads first; the buffer drains in gaps,
    // and forcibly when full so a write never meets a closed buffer
    assign drain_rdy = !st_r.rd1_v || wb_full;

    sbsp_wbuf #(
        .ADDR_W(ADDR_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .in_valid(is_write),
        .in_ready(push_rdy),
        .in_addr(acc_addr),
        .in_data(din),
        .in_mask(wr_mask),
        .out_valid(drain_v),
        .out_ready(drain_rdy),
        .out_addr(drain_addr),
        .out_data(drain_data),
        .out_mask(drain_mask),
        .is_full(wb_full),
        .lk_addr(st_r.rd1_addr),
        .lk_data(lk_data),
        .lk_mask(lk_mask)
    );

    // Array update from the buffer head; data storage needs no reset
    always_ff @(posedge clk_sys) begin
        if (ce && drain_v && drain_rdy) begin
            mem[drain_addr] <= sbsp_merge(mem[drain_addr], drain_data, drain_mask);
        end
    end

    assign mem_rd = mem[st_r.rd1_addr];

    // ----------------------------------------
    // Address, control and read pipeline
    // ----------------------------------------

    // Capture, array read and output register: data sits on the pins
    // after the second edge past capture, sampled on the third
    always_comb begin
        st_nxt = st_r;
        if (new_go) begin
            st_nxt.mode = sel_all ? SBSP_BURST : SBSP_IDLE;
            st_nxt.base = address_in[ADDR_W-1:2];
            st_nxt.start_lo = address_in[1:0];
            st_nxt.cnt = 2'h0;
        end else if (cont) begin
            st_nxt.cnt = cnt_next;
        end
        st_nxt.rd1_v = acc_now && !is_write;
        st_nxt.rd1_addr = acc_addr;
        st_nxt.rd2_v = st_r.rd1_v && !desel_now;
        if (st_r.rd1_v) begin
            st_nxt.rd2_data = sbsp_merge(mem_rd, lk_data, lk_mask);
        end
        if (st_r.rd2_v) begin
            st_nxt.dout = st_r.rd2_data;
        end
        // Deselect or write turns drivers off at the very next edge
        st_nxt.doe = st_r.rd2_v && !desel_now && !float_now && !is_write;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= PORT_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------

    // Output enable gates the drivers without the clock; this is the one
    // path that is not straight from a flip-flop, by intent
    assign data_low_byte_out = st_r.dout[`SBSP_LOW_LSB +: `SBSP_DATA_W];
    assign parity_low_byte_out = st_r.dout[`SBSP_LOW_PAR];
    assign data_high_byte_out = st_r.dout[`SBSP_HIGH_LSB +: `SBSP_DATA_W];
    assign parity_high_byte_out = st_r.dout[`SBSP_HIGH_PAR];
    assign data_low_byte_oe = st_r.doe && !output_enable_n;
    assign parity_low_byte_oe = st_r.doe && !output_enable_n;
    assign data_high_byte_oe = st_r.doe && !output_enable_n;
    assign parity_high_byte_oe = st_r.doe && !output_enable_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    a_read_latency: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && acc_now && !is_write)
        ##1 (ce && !desel_now && !float_now && !is_write)
        ##1 (ce && !desel_now && !float_now && !is_write)
        |=> st_r.doe
    ) else $error("read word not driven on the third edge");

    a_read_not_early: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && !st_r.rd1_v && !st_r.rd2_v) |=> !st_r.doe
    ) else $error("drivers on without a read in the pipe");

    a_deselect_release: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && desel_now) |=> (!st_r.doe && st_r.mode == SBSP_IDLE)
    ) else $error("bus not released one clock after deselect");

    a_write_float: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && float_now) |=> !data_low_byte_oe && !data_high_byte_oe
    ) else $error("pins driven during a byte write");

    a_oe_async: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        output_enable_n |-> !data_low_byte_oe && !parity_high_byte_oe
    ) else $error("drivers on with output enable high");

    a_proc_ignored: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && chip_select_n && ctrl_addr_strobe_n && !in_burst) |=> !st_r.rd1_v
    ) else $error("processor strobe taken with primary select high");

    a_second_sel: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && new_go && (second_select_n || !third_select_high)) |=> (st_r.mode == SBSP_IDLE)
    ) else $error("selected with a chip select inactive");

    a_proc_reads: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && proc_go && sel_all) |=> (st_r.rd1_v && st_r.rd1_addr == $past(address_in))
    ) else $error("processor strobe did not start a read at the new address");

    a_global_write: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && is_write && !all_bytes_write_n) |-> (wr_mask == 2'h3)
    ) else $error("global write did not select both bytes");

    a_gate_blocks: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && all_bytes_write_n && byte_write_gate_n) |-> !is_write
    ) else $error("write decoded with the byte gate high");

    a_burst_step: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && adv) |=> (st_r.cnt == 2'($past(st_r.cnt) + 2'h1))
    ) else $error("burst counter did not advance");

    a_wait_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && cont && burst_advance_n) |=> (st_r.cnt == $past(st_r.cnt))
    ) else $error("counter moved in a wait cycle");

    a_upper_stable: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && cont) |=> (st_r.base == $past(st_r.base) && st_r.rd1_addr[ADDR_W-1:2] == st_r.base)
    ) else $error("upper address bits changed inside a burst");

    a_linear_order: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && adv && !burst_order_sel) |=> (st_r.rd1_addr[1:0] == 2'(st_r.start_lo + st_r.cnt))
    ) else $error("linear burst address wrong");

    a_push_taken: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && is_write) |-> push_rdy
    ) else $error("posted write refused by the buffer");

    a_pass_through: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && st_r.rd1_v && lk_mask == 2'h3) |=> (st_r.rd2_data == $past(lk_data))
    ) else $error("pending write not returned to a read");

endmodule : sbsp_port

// [sbsp_master.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Bus master model
// ----------------------------------------
// Changes pins only after a falling edge, so each request stands a whole cycle
module sbsp_master (
    input wire logic clk_sys,
    input wire logic oe_seen,
    input wire logic [17:0] bus_word,
    output logic [15:0] address_in,
    output logic chip_select_n,
    output logic second_select_n,
    output logic third_select_high,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_advance_n,
    output logic all_bytes_write_n,
    output logic byte_write_gate_n,
    output logic low_byte_write_n,
    output logic high_byte_write_n,
    output logic output_enable_n,
    output logic burst_order_sel,
    output logic [17:0] drive_word
);
    logic [18:0] obs[$];

    // Quiet bus at time zero: no strobe, no write, outputs enabled
    initial begin
        address_in = 16'h0000;
        {chip_select_n, second_select_n, third_select_high} = 3'b001;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'b111;
        {all_bytes_write_n, byte_write_gate_n, low_byte_write_n, high_byte_write_n} = 4'hf;
        output_enable_n = 1'b0;
        burst_order_sel = 1'b1;
        drive_word = 18'h15555;
    end

    // One bus cycle; the bus as seen just before the change is logged
    task automatic cycle(input logic [1:0] strb, input logic [2:0] sel, input logic adv, input logic [3:0] wr,
                         input logic [15:0] a, input logic [17:0] d);
        logic wr_req;
        @(negedge clk_sys);
        obs.push_back({oe_seen, bus_word});
        wr_req = !wr[3] || (!wr[2] && !(wr[1] && wr[0]));
        // A write that meets a driven bus turns the device's drivers off first,
        // else both sides would fight and the device would latch its own word
        output_enable_n = wr_req && oe_seen;
        {proc_addr_strobe_n, ctrl_addr_strobe_n} = strb;
        {chip_select_n, second_select_n, third_select_high} = sel;
        burst_advance_n = adv;
        {all_bytes_write_n, byte_write_gate_n, low_byte_write_n, high_byte_write_n} = wr;
        address_in = a;
        // A released line toggles, so a stale word never passes for a read
        drive_word = wr_req ? d : ~drive_word;
    endtask : cycle
endmodule : sbsp_master

// [tb_sync_burst_sram_port.sv]
`timescale 1ns/1ps

module tb_sync_burst_sram_port;
    import sbsp_pkg::*;
    localparam logic [2:0] SEL = 3'b001;
    localparam logic [2:0] DESEL = 3'b011;
    localparam logic [3:0] RD = 4'hf;
    localparam logic [3:0] GW = 4'h7;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    sbsp_word_t mem [logic [15:0]];
    logic [7:0] dl_o;
    logic [7:0] dh_o;
    logic pl_o, ph_o, oe_dl, oe_pl, oe_dh, oe_ph, oe_all;
    logic [17:0] bus_word;
    logic [17:0] drv;
    logic [15:0] a_in;
    logic cs_n, cs2_n, cs3, ps_n, cs_strb_n, adv_n, gw_n, bwe_n, wel_n, weh_n, oe_n, ord;

    // ----------------------------------------
    // Clock, wire resolution, parts
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;

    // Device drives the shared data lines only while all its enables are up
    assign oe_all = oe_dl & oe_pl & oe_dh & oe_ph;
    assign bus_word = oe_all ? {ph_o, dh_o, pl_o, dl_o} : drv;

    sbsp_master m (.clk_sys(clk_sys), .oe_seen(oe_all), .bus_word(bus_word), .address_in(a_in),
        .chip_select_n(cs_n), .second_select_n(cs2_n), .third_select_high(cs3), .proc_addr_strobe_n(ps_n),
        .ctrl_addr_strobe_n(cs_strb_n), .burst_advance_n(adv_n), .all_bytes_write_n(gw_n),
        .byte_write_gate_n(bwe_n), .low_byte_write_n(wel_n), .high_byte_write_n(weh_n),
        .output_enable_n(oe_n), .burst_order_sel(ord), .drive_word(drv));

    sbsp_port dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .address_in(a_in), .chip_select_n(cs_n),
        .second_select_n(cs2_n), .third_select_high(cs3), .proc_addr_strobe_n(ps_n),
        .ctrl_addr_strobe_n(cs_strb_n), .burst_advance_n(adv_n), .low_byte_write_n(wel_n),
        .high_byte_write_n(weh_n), .byte_write_gate_n(bwe_n), .all_bytes_write_n(gw_n),
        .output_enable_n(oe_n), .burst_order_sel(ord), .data_low_byte_in(bus_word[7:0]),
        .parity_low_byte_in(bus_word[8]), .data_high_byte_in(bus_word[16:9]), .parity_high_byte_in(bus_word[17]),
        .data_low_byte_out(dl_o), .parity_low_byte_out(pl_o), .data_high_byte_out(dh_o),
        .parity_high_byte_out(ph_o), .data_low_byte_oe(oe_dl), .parity_low_byte_oe(oe_pl),
        .data_high_byte_oe(oe_dh), .parity_high_byte_oe(oe_ph));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Write cycle; the model merges only the lanes that the controls select
    task automatic wr(input logic [1:0] strb, input logic [15:0] a, input sbsp_word_t d, input logic [3:0] w);
        sbsp_word_t lanes;
        lanes = !w[3] ? 18'h3ffff : {{9{!w[2] && !w[0]}}, {9{!w[2] && !w[1]}}};
        mem[a] = (mem[a] & ~lanes) | (d & lanes);
        m.cycle(strb, SEL, 1'b1, w, a, d);
    endtask : wr

    // Burst of five words; continuation cycles carry a wrong address on purpose
    task automatic run_burst(input logic [1:0] strb, input logic [15:0] a0, input logic [3:0] advs);
        logic [1:0] cnt;
        logic [1:0] lo;
        cnt = 2'h0;
        m.obs.delete();
        m.cycle(strb, SEL, 1'b1, RD, a0, 18'h0);
        for (int i = 0; i < 4; i++) begin
            m.cycle(2'b11, SEL, advs[i], RD, ~a0, 18'h0);
        end
        repeat (3) m.cycle(2'b11, SEL, 1'b1, RD, ~a0, 18'h0);
        for (int j = 0; j < 5; j++) begin
            if (j > 0 && !advs[j-1]) begin
                cnt++;
            end
            lo = ord ? (a0[1:0] ^ cnt) : (a0[1:0] + cnt);
            chk(m.obs[j+3], {1'b1, mem[{a0[15:2], lo}]});
        end
        m.cycle(2'b10, DESEL, 1'b1, RD, a0, 18'h0);
    endtask : run_burst

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_interleave();
        m.burst_order_sel = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(2'b10, 16'h1230 + 16'(i), 18'h2c000 ^ 18'(i * 'h111), GW);
        end
        run_burst(2'b10, 16'h1232, 4'b0010);
        $display("TB: interleaved burst done");
    endtask : t_interleave

    task automatic t_linear();
        m.burst_order_sel = 1'b0;
        run_burst(2'b01, 16'h1233, 4'b0000);
        $display("TB: linear burst done");
    endtask : t_linear

    // Byte writes land in the middle of a read burst, where floating is visible
    task automatic t_lanes();
        m.obs.delete();
        wr(2'b10, 16'h0450, 18'h00000, GW);
        m.cycle(2'b10, SEL, 1'b1, RD, 16'h0450, 18'h0);
        m.cycle(2'b11, SEL, 1'b1, RD, 16'h0450, 18'h0);
        wr(2'b11, 16'h0450, 18'h3ffff, 4'b1001);
        m.cycle(2'b11, SEL, 1'b1, 4'b1100, 16'h0450, 18'h3ffff);
        wr(2'b11, 16'h0450, 18'h2aaaa, 4'b1010);
        repeat (3) m.cycle(2'b11, SEL, 1'b1, RD, 16'h0450, 18'h0);
        chk(19'(m.obs[4][18]), 19'h0);
        chk(m.obs[5], {1'b1, 18'h00000});
        chk(m.obs[7], {1'b1, 18'h001ff});
        m.cycle(2'b10, DESEL, 1'b1, RD, 16'h0450, 18'h0);
        run_burst(2'b10, 16'h0450, 4'b1111);
        $display("TB: byte lanes done");
    endtask : t_lanes

    task automatic t_selects();
        m.obs.delete();
        m.cycle(2'b01, 3'b101, 1'b1, RD, 16'h1230, 18'h0);
        m.cycle(2'b01, 3'b011, 1'b1, RD, 16'h1230, 18'h0);
        m.cycle(2'b10, 3'b000, 1'b1, RD, 16'h1230, 18'h0);
        repeat (3) m.cycle(2'b11, SEL, 1'b1, RD, 16'h1230, 18'h0);
        for (int j = 3; j < 6; j++) begin
            chk(19'(m.obs[j][18]), 19'h0);
        end
        m.obs.delete();
        m.cycle(2'b01, SEL, 1'b1, RD, 16'h1231, 18'h0);
        repeat (3) m.cycle(2'b11, SEL, 1'b1, RD, 16'h1231, 18'h0);
        m.cycle(2'b10, DESEL, 1'b1, RD, 16'h1231, 18'h0);
        m.cycle(2'b11, SEL, 1'b1, RD, 16'h1231, 18'h0);
        chk(m.obs[3], {1'b1, mem[16'h1231]});
        chk(19'(m.obs[4][18]), 19'h1);
        chk(19'(m.obs[5][18]), 19'h0);
        $display("TB: selects done");
    endtask : t_selects

    // Output enable acts between clock edges
    task automatic t_oe_async();
        m.cycle(2'b10, SEL, 1'b1, RD, 16'h1230, 18'h0);
        repeat (3) m.cycle(2'b11, SEL, 1'b1, RD, 16'h1230, 18'h0);
        #1;
        chk(19'(oe_all), 19'h1);
        m.output_enable_n = 1'b1;
        #1;
        chk(19'(oe_all), 19'h0);
        m.output_enable_n = 1'b0;
        #1;
        chk(19'(oe_all), 19'h1);
        m.cycle(2'b10, DESEL, 1'b1, RD, 16'h1230, 18'h0);
        $display("TB: output enable done");
    endtask : t_oe_async

    // More posted writes than buffer entries, back to back, then read back
    task automatic t_fill();
        m.burst_order_sel = 1'b0;
        for (int i = 0; i < 12; i++) begin
            wr(2'b10, 16'h2000 + 16'(i), 18'h10000 ^ 18'(i * 'h305), GW);
        end
        for (int i = 0; i < 3; i++) begin
            run_burst(2'b10, 16'h2000 + 16'(4 * i), 4'b0000);
        end
        $display("TB: buffer fill done");
    endtask : t_fill

    // ----------------------------------------
    // Closing and watchdog
    // ----------------------------------------
    task automatic wrap_up();
        $display("TB: checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Run needs about a hundred cycles; a hang is cut well after that
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            wrap_up();
        end
    end

    // Reset held three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        t_interleave();
        t_linear();
        t_lanes();
        t_selects();
        t_oe_async();
        t_fill();
        wrap_up();
    end
endmodule : tb_sync_burst_sram_port
